// *** fpcs_map.vh ***
// Register map, field positions and timing constants of the signaling compare unit.
`ifndef FPCS_MAP_VH
`define FPCS_MAP_VH
`define FPCS_ADR_CTRL 9'h000
`define FPCS_ADR_INSTR 9'h004
`define FPCS_ADR_FSR 9'h008
`define FPCS_ADR_STAT 9'h00C
`define FPCS_ADR_RF 9'h100
`define FPCS_CTRL_RST 32'h0000_0000
`define FPCS_FSR_RST 32'h0000_0000
`define FPCS_C_FPEN 0
`define FPCS_C_FP16 1
`define FPCS_C_CTIME 2
`define FPCS_C_COMPACT 3
`define FPCS_C_INIT 4
`define FPCS_C_POL_LO 5
`define FPCS_C_POL_HI 6
`define FPCS_C_ITC_LO 8
`define FPCS_C_ITC_HI 11
`define FPCS_C_NZCV_LO 28
`define FPCS_C_NZCV_HI 31
`define FPCS_F_IOC 0
`define FPCS_POL_UNDEF 2'h0
`define FPCS_POL_EXEC 2'h1
`define FPCS_COND_AL 4'hE
`define FPCS_COND_NV 4'hF
`define FPCS_LAT 4'h3
`endif

// *** fpcs_decode.v ***
// Field decode of the signaling compare in both instruction sets.
`timescale 1ns/10ps
`include "fpcs_map.vh"
module fpcs_decode (
    input wire [31:0] instr_i,
    input wire compact_i,
    output wire match_o,
    output wire with_zero_o,
    output wire sig_sel_o,
    output wire [1:0] prec_o,
    output wire [5:0] first_idx_o,
    output wire [5:0] second_idx_o
);
    wire [3:0] cond;
    wire base;
    assign cond = instr_i[31:28];
    // The compact form is the fixed-length word with the top nibble fixed at 1110.
    assign base = (instr_i[27:23] == 5'h1D) && (instr_i[21:17] == 5'h1A) &&
                  (instr_i[11:10] == 2'h2) && instr_i[6] && !instr_i[4];
    assign match_o = base && (compact_i ? (cond == `FPCS_COND_AL) : (cond != `FPCS_COND_NV));
    assign with_zero_o = instr_i[16];
    assign sig_sel_o = instr_i[7];
    assign prec_o = instr_i[9:8];
    assign first_idx_o = (instr_i[9:8] == 2'h3) ?
        {1'b0, instr_i[22], instr_i[15:12]} : {1'b0, instr_i[15:12], instr_i[22]};
    assign second_idx_o = (instr_i[9:8] == 2'h3) ?
        {1'b0, instr_i[5], instr_i[3:0]} : {1'b0, instr_i[3:0], instr_i[5]};
endmodule

// *** fpcs_fcmp.v ***
// Floating-point compare of two operands in half, single or double precision.
`timescale 1ns/10ps
module fpcs_fcmp (
    input wire [63:0] a_i,
    input wire [63:0] b_i,
    input wire [1:0] prec_i,
    input wire sig_sel_i,
    output wire [3:0] nzcv_o,
    output wire invalid_o
);
    // Magnitude left-aligned to 63 bits so one comparator serves all widths.
    function [62:0] mag;
        input [63:0] v;
        input [1:0] p;
        begin
            case (p)
                2'h1: mag = {v[14:0], 48'h0};
                2'h2: mag = {v[30:0], 32'h0};
                default: mag = v[62:0];
            endcase
        end
    endfunction
    function sgn;
        input [63:0] v;
        input [1:0] p;
        begin
            case (p)
                2'h1: sgn = v[15];
                2'h2: sgn = v[31];
                default: sgn = v[63];
            endcase
        end
    endfunction
    function is_nan;
        input [62:0] m;
        input [1:0] p;
        begin
            case (p)
                2'h1: is_nan = (m[62:58] == 5'h1F) && (m[57:48] != 10'h0);
                2'h2: is_nan = (m[62:55] == 8'hFF) && (m[54:32] != 23'h0);
                default: is_nan = (m[62:52] == 11'h7FF) && (m[51:0] != 52'h0);
            endcase
        end
    endfunction
    function is_snan;
        input [62:0] m;
        input [1:0] p;
        begin
            case (p)
                2'h1: is_snan = !m[57];
                2'h2: is_snan = !m[54];
                default: is_snan = !m[51];
            endcase
        end
    endfunction
    wire [62:0] ma;
    wire [62:0] mb;
    wire sa;
    wire sb;
    wire na;
    wire nb;
    wire eq;
    wire lt;
    assign ma = mag(a_i, prec_i);
    assign mb = mag(b_i, prec_i);
    assign sa = sgn(a_i, prec_i);
    assign sb = sgn(b_i, prec_i);
    assign na = is_nan(ma, prec_i);
    assign nb = is_nan(mb, prec_i);
    // Both zeros compare equal whatever their signs.
    assign eq = ((ma == 63'h0) && (mb == 63'h0)) || ((sa == sb) && (ma == mb));
    assign lt = !eq && ((sa != sb) ? sa : (sa ? (ma > mb) : (ma < mb)));
    assign nzcv_o = (na || nb) ? 4'h3 : eq ? 4'h6 : lt ? 4'h8 : 4'h2;
    // The signaling compare traps on every NaN; with the select bit clear only signaling NaNs do.
    assign invalid_o = sig_sel_i ? (na || nb) :
        ((na && is_snan(ma, prec_i)) || (nb && is_snan(mb, prec_i)));
endmodule

// *** fpcs_top.v ***
// Signaling compare unit with operand file, status register and classic bus slave.
//
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "fpcs_map.vh"
module fpcs_top (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [8:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output wire [31:0] dat_o,
    output wire ack_o
);
    // ------------------------------------------------------------------
    // Local states and helpers
    // ------------------------------------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_EXEC = 2'h1;
    localparam ST_DONE = 2'h2;

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] sel;
        integer k;
        begin
            merge = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (sel[k]) begin
                    merge[k*8 +: 8] = nw[k*8 +: 8];
                end
            end
        end
    endfunction

    function cond_ok;
        input [3:0] c;
        input [3:0] f;
        reg r;
        begin
            case (c[3:1])
                3'h0: r = f[2];
                3'h1: r = f[1];
                3'h2: r = f[3];
                3'h3: r = f[0];
                3'h4: r = f[1] && !f[2];
                3'h5: r = (f[3] == f[0]);
                3'h6: r = !f[2] && (f[3] == f[0]);
                default: r = 1'b1;
            endcase
            cond_ok = (c[0] && (c != `FPCS_COND_NV)) ? !r : r;
        end
    endfunction

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    reg [31:0] rf [0:63];
    reg [31:0] ctrl_ff;
    reg [31:0] instr_ff;
    reg [31:0] fsr_ff;
    reg [31:0] dat_ff;
    reg ack_ff;
    reg [1:0] state_ff;
    reg [3:0] cnt_ff;
    reg [63:0] opa_ff;
    reg [63:0] opb_ff;
    reg [1:0] prec_ff;
    reg sig_ff;
    reg go_ff;
    reg undef_ff;
    reg nomatch_ff;
    reg skipped_ff;
    reg done_ff;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire req;
    wire busy;
    wire hold;
    wire wr;
    wire rd;
    wire is_rf;
    wire issue;
    assign req = cyc_i && stb_i && !ack_ff;
    assign busy = (state_ff != ST_IDLE);
    // A new instruction waits for the previous one; the bus simply stalls.
    assign hold = we_i && (adr_i == `FPCS_ADR_INSTR) && busy;
    assign wr = req && we_i && !hold;
    assign rd = req && !we_i;
    assign is_rf = adr_i[8];
    assign issue = wr && (adr_i == `FPCS_ADR_INSTR);
    assign ack_o = ack_ff;
    assign dat_o = dat_ff;

    // ------------------------------------------------------------------
    // Decode of the word being issued
    // ------------------------------------------------------------------
    wire [31:0] new_instr;
    wire match;
    wire with_zero;
    wire sig_sel;
    wire [1:0] prec;
    wire [5:0] fidx;
    wire [5:0] sidx;
    assign new_instr = merge(instr_ff, dat_i, sel_i);

    fpcs_decode u_dec (
        .instr_i(new_instr),
        .compact_i(ctrl_ff[`FPCS_C_COMPACT]),
        .match_o(match),
        .with_zero_o(with_zero),
        .sig_sel_o(sig_sel),
        .prec_o(prec),
        .first_idx_o(fidx),
        .second_idx_o(sidx)
    );

    wire compact;
    wire in_it;
    wire fp16;
    wire [1:0] pol;
    wire [3:0] eff_cond;
    wire unpred;
    wire bad_prec;
    wire pass;
    wire do_undef;
    wire do_exec;
    assign compact = ctrl_ff[`FPCS_C_COMPACT];
    assign in_it = ctrl_ff[`FPCS_C_INIT];
    assign fp16 = ctrl_ff[`FPCS_C_FP16];
    assign pol = ctrl_ff[`FPCS_C_POL_HI:`FPCS_C_POL_LO];
    // Compact instructions take their condition from the if-then state inside an if-then block, and 1110 (always) outside one.
    assign eff_cond = compact ? (in_it ? ctrl_ff[`FPCS_C_ITC_HI:`FPCS_C_ITC_LO] : `FPCS_COND_AL) :
        new_instr[31:28];
    assign bad_prec = (prec == 2'h0) || ((prec == 2'h1) && !fp16);
    assign unpred = (prec == 2'h1) &&
        (compact ? in_it : (new_instr[31:28] != `FPCS_COND_AL));
    // The selectable policy picks one of the three permitted outcomes.
    assign pass = unpred ? (pol == `FPCS_POL_EXEC) :
        cond_ok(eff_cond, ctrl_ff[`FPCS_C_NZCV_HI:`FPCS_C_NZCV_LO]);
    assign do_undef = match && (bad_prec || (unpred && (pol == `FPCS_POL_UNDEF)) ||
        (pass && !ctrl_ff[`FPCS_C_FPEN]));
    assign do_exec = match && !do_undef && pass;

    // ------------------------------------------------------------------
    // Operand fetch
    // ------------------------------------------------------------------
    wire [63:0] fa;
    wire [63:0] fb;
    wire [5:0] fa_lo;
    wire [5:0] fb_lo;
    // A double register n occupies single registers 2n and 2n+1.
    assign fa_lo = {fidx[4:0], 1'b0};
    assign fb_lo = {sidx[4:0], 1'b0};
    assign fa = (prec == 2'h3) ? {rf[fa_lo | 6'h01], rf[fa_lo]} :
        {32'h0, rf[fidx]};
    assign fb = with_zero ? 64'h0 : (prec == 2'h3) ? {rf[fb_lo | 6'h01], rf[fb_lo]} :
        {32'h0, rf[sidx]};

    wire [3:0] nzcv;
    wire invalid;

    fpcs_fcmp u_cmp (
        .a_i(opa_ff),
        .b_i(opb_ff),
        .prec_i(prec_ff),
        .sig_sel_i(sig_ff),
        .nzcv_o(nzcv),
        .invalid_o(invalid)
    );

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Every issued word, executed, skipped or undefined, spends the same
    // number of cycles, so timing reveals neither data nor flags.
    reg [1:0] nxt_state;
    reg [3:0] nxt_cnt;
    always @* begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            ST_IDLE: begin
                if (issue) begin
                    nxt_state = ST_EXEC;
                    nxt_cnt = `FPCS_LAT;
                end
            end
            ST_EXEC: begin
                if (cnt_ff == 4'h1) begin
                    nxt_state = ST_DONE;
                end
                nxt_cnt = cnt_ff - 4'h1;
            end
            ST_DONE: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    wire commit;
    assign commit = (state_ff == ST_DONE) && go_ff;

    always @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= ST_IDLE;
            cnt_ff <= 4'h0;
            go_ff <= 1'b0;
            opa_ff <= 64'h0;
            opb_ff <= 64'h0;
            prec_ff <= 2'h0;
            sig_ff <= 1'b0;
            undef_ff <= 1'b0;
            nomatch_ff <= 1'b0;
            skipped_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            if (issue) begin
                go_ff <= do_exec;
                opa_ff <= fa;
                opb_ff <= fb;
                prec_ff <= prec;
                sig_ff <= sig_sel;
                undef_ff <= do_undef;
                nomatch_ff <= !match;
                skipped_ff <= match && !do_undef && !pass;
                done_ff <= 1'b0;
            end else if (state_ff == ST_DONE) begin
                done_ff <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Status and control register
    // ------------------------------------------------------------------
    // The unit has no interruptible point: the compare completes whole,
    // so asynchronous events never see data-dependent behaviour.
    reg [31:0] nxt_fsr;
    always @* begin
        nxt_fsr = fsr_ff;
        if (wr && (adr_i == `FPCS_ADR_FSR)) begin
            nxt_fsr = merge(fsr_ff, dat_i, sel_i);
        end
        if (commit) begin
            nxt_fsr[31:28] = nzcv;
            if (invalid) begin
                nxt_fsr[`FPCS_F_IOC] = 1'b1;
            end
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            fsr_ff <= `FPCS_FSR_RST;
            ctrl_ff <= `FPCS_CTRL_RST;
            instr_ff <= 32'h0;
        end else begin
            fsr_ff <= nxt_fsr;
            if (wr && (adr_i == `FPCS_ADR_CTRL)) begin
                ctrl_ff <= merge(ctrl_ff, dat_i, sel_i);
            end
            if (issue) begin
                instr_ff <= new_instr;
            end
        end
    end

    // ------------------------------------------------------------------
    // Operand file
    // ------------------------------------------------------------------
    // Contents are data only, so they are left without reset.
    always @(posedge clk_i) begin
        if (wr && is_rf) begin
            rf[adr_i[7:2]] <= merge(rf[adr_i[7:2]], dat_i, sel_i);
        end
    end

    // ------------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------------
    wire [31:0] stat_word;
    assign stat_word = {27'h0, done_ff, skipped_ff, nomatch_ff, undef_ff, busy};

    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h0;
        if (is_rf) begin
            rd_mux = rf[adr_i[7:2]];
        end else begin
            case (adr_i)
                `FPCS_ADR_CTRL: rd_mux = ctrl_ff;
                `FPCS_ADR_INSTR: rd_mux = instr_ff;
                `FPCS_ADR_FSR: rd_mux = fsr_ff;
                `FPCS_ADR_STAT: rd_mux = stat_word;
                default: rd_mux = 32'h0;
            endcase
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0;
        end else begin
            ack_ff <= req && !hold;
            if (rd) begin
                dat_ff <= rd_mux;
            end
        end
    end
endmodule

// *** fpcs_top_props.sv ***
// Bus timing and status checks of the signaling compare unit.
`timescale 1ns/10ps
module fpcs_top_chk (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [8:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    input wire [31:0] dat_o,
    input wire ack_o
);
    // ----
    // Issue tracking
    // ----
    // Cycles since the last issue was acknowledged; 15 means none since reset.
    reg [3:0] since_ff;
    wire issue = ack_o && we_i && adr_i[8:2] == 7'h01;
    wire stat_rd = ack_o && !we_i && adr_i[8:2] == 7'h03;
    always @(posedge clk_i) begin
        if (rst_i)
            since_ff <= 4'hF;
        else if (issue)
            since_ff <= 4'h0;
        else if (since_ff < 4'hE)
            since_ff <= since_ff + 4'h1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    ack_bound_a: assert property (cyc_i && stb_i && !ack_o |-> ##[1:8] ack_o)
        else $error("request not answered");
    ack_fast_a: assert property (cyc_i && stb_i && !ack_o && !(we_i && adr_i[8:2] == 7'h01) |=> ack_o)
        else $error("plain access not answered next cycle");
    unmapped_zero_a: assert property (ack_o && !we_i && !adr_i[8] && adr_i[7:2] > 6'h03 |-> dat_o == 32'h0)
        else $error("unmapped read not zero");
    status_upper_a: assert property (stat_rd |-> dat_o[31:5] == 27'h0)
        else $error("status spare bits set");
    status_busy_a: assert property (stat_rd && since_ff <= 4'h2 |-> dat_o[0] && !dat_o[4])
        else $error("unit not busy right after issue");
    status_done_a: assert property (stat_rd && since_ff >= 4'h4 && since_ff != 4'hF |-> dat_o[4] && !dat_o[0])
        else $error("unit not done four cycles after issue");
    reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> !ack_o && dat_o == 32'h0)
        else $error("bus outputs active after reset");
endmodule
bind fpcs_top fpcs_top_chk fpcs_top_chk_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o));

// *** fpcs_pipe_model.sv ***
// Pipeline-side model issuing words and operands over the classic bus.
`timescale 1ns/10ps
module fpcs_pipe_model (
    input wire clk_i,
    input wire ack_i,
    input wire [31:0] dat_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [8:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 9'h0;
        sel_o = 4'h0;
        dat_o = 32'h0;
    end
    // Entered just after a rising edge; the request stands until ack is sampled high.
    task automatic xfer(input logic w, input logic [8:0] a, input logic [31:0] d, output logic [31:0] q);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        sel_o <= 4'hF;
        dat_o <= d;
        @(posedge clk_i);
        while (ack_i !== 1'b1)
            @(posedge clk_i);
        q = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o <= 1'b0;
        // Released lines flip so a stale word can never pass for a live one.
        adr_o <= ~a;
        dat_o <= ~d;
        sel_o <= 4'h0;
        @(posedge clk_i);
    endtask
endmodule

// *** tb.sv ***
// Self-checking bench of the signaling compare unit.
`timescale 1ns/10ps
module tb;
    logic clk_i;
    logic rst_i = 1'b1;
    wire cyc_i, stb_i, we_i, ack_o;
    wire [8:0] adr_i;
    wire [3:0] sel_i;
    wire [31:0] dat_i, dat_o;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    int k;
    logic [31:0] lfsr_ff = 32'h121F_DFF5;
    logic [31:0] got, r;
    logic [31:0] rf [64];
    logic [31:0] iv [12] = '{32'h3F80_0000, 32'h4000_0000, 32'h7FC0_0000, 32'h8000_0000, 32'h7F80_0001,
        32'hABCD_3C00, 32'h1234_4000, 32'h5A5A_FE00, 32'h0, 32'h3FF0_0000, 32'h0, 32'hC000_0000};
    localparam logic [31:0] base_ctrl = 32'h3;
    fpcs_top fpcs_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o));
    fpcs_pipe_model fpcs_pipe_model_inst (.clk_i(clk_i), .ack_i(ack_o), .dat_i(dat_o), .cyc_o(cyc_i),
        .stb_o(stb_i), .we_o(we_i), .adr_o(adr_i), .sel_o(sel_i), .dat_o(dat_i));
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            mismatches++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (mismatches == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    function automatic logic [31:0] rnd();
        repeat (32) lfsr_ff = {lfsr_ff[30:0], ^(lfsr_ff & 32'h8020_0003)};
        return lfsr_ff;
    endfunction
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        logic [31:0] q;
        fpcs_pipe_model_inst.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [8:0] a, output logic [31:0] q);
        fpcs_pipe_model_inst.xfer(1'b0, a, 32'h0, q);
    endtask
    task automatic setr(input logic [5:0] n, input logic [31:0] v);
        rf[n] = v;
        wr({1'b1, n, 2'h0}, v);
    endtask
    // Signed ordering key; both zeros map to 0 so they compare equal.
    function automatic longint key(input logic [63:0] v, input int mw, input int ew, output logic nan,
                                   output logic snan);
        longint mag;
        mag = v & ((64'h1 << (mw + ew)) - 64'h1);
        nan = (mag >> mw) == ((64'h1 << ew) - 64'h1) && (mag & ((64'h1 << mw) - 64'h1)) != 0;
        snan = nan && !v[mw - 1];
        return v[mw + ew] ? -mag : mag;
    endfunction
    function automatic logic [31:0] mk(input logic [3:0] c, input logic [4:0] n, input logic z,
                                       input logic [1:0] p, input logic e, input logic [4:0] q);
        logic [4:0] x, y;
        x = p == 2'h3 ? {n[3:0], n[4]} : n;
        y = p == 2'h3 ? {q[3:0], q[4]} : q;
        return {c, 5'h1D, x[0], 5'h1A, z, x[4:1], 2'h2, p, e, 1'b1, y[0], 1'b0, y[4:1]};
    endfunction
    // Condition check from the core flags {N, Z, C, V}; code 1111 counts as always.
    function automatic logic cpass(input logic [3:0] c, input logic [3:0] f);
        logic [15:0] t;
        t = {1'b1, 1'b1, f[2] || f[3] != f[0], !f[2] && f[3] == f[0], f[3] != f[0], f[3] == f[0],
            !f[1] || f[2], f[1] && !f[2], !f[0], f[0], !f[3], f[3], !f[1], f[1], !f[2], f[2]};
        return t[c];
    endfunction
    task automatic run(input logic [31:0] ctrl, input logic [31:0] ins);
        logic [31:0] pre, st, q;
        logic [63:0] a, b;
        logic [3:0] c, nzcv;
        logic [1:0] p;
        logic [5:0] d, m;
        logic match, pass, unp, na, nb, sa, sb, inv;
        logic [4:0] ex;
        longint ka, kb;
        int mw, ew, i;
        pre = rnd() & 32'hFFFF_FFFE;
        p = ins[9:8];
        match = ins[27:23] == 5'h1D && ins[21:17] == 5'h1A && ins[11:10] == 2'h2 && ins[6] && !ins[4]
            && (ctrl[3] ? ins[31:28] == 4'hE : ins[31:28] != 4'hF);
        c = ctrl[3] ? (ctrl[4] ? ctrl[11:8] : 4'hE) : ins[31:28];
        pass = cpass(c, ctrl[31:28]);
        unp = p == 2'h1 && (ctrl[3] ? ctrl[4] : ins[31:28] != 4'hE);
        if (!match)
            ex = 5'h14;
        else if (p == 2'h0 || (p == 2'h1 && !ctrl[1]) || (unp && ctrl[6:5] == 2'h0))
            ex = 5'h12;
        else if (unp ? ctrl[6] : !pass)
            ex = 5'h18;
        else
            ex = ctrl[0] ? 5'h10 : 5'h12;
        d = p == 2'h3 ? {ins[22], ins[15:12], 1'b0} : {ins[15:12], ins[22]};
        m = p == 2'h3 ? {ins[5], ins[3:0], 1'b0} : {ins[3:0], ins[5]};
        a = p == 2'h3 ? {rf[d + 6'h1], rf[d]} : {32'h0, rf[d]};
        b = ins[16] ? 64'h0 : p == 2'h3 ? {rf[m + 6'h1], rf[m]} : {32'h0, rf[m]};
        mw = p == 2'h3 ? 52 : p == 2'h2 ? 23 : 10;
        ew = p == 2'h3 ? 11 : p == 2'h2 ? 8 : 5;
        ka = key(a, mw, ew, na, sa);
        kb = key(b, mw, ew, nb, sb);
        nzcv = (na || nb) ? 4'h3 : ka < kb ? 4'h8 : ka == kb ? 4'h6 : 4'h2;
        inv = ins[7] ? (na || nb) : (sa || sb);
        wr(9'h000, ctrl);
        wr(9'h008, pre);
        wr(9'h004, ins);
        st = 32'h0;
        for (i = 0; i < 10 && st[4] !== 1'b1; i++)
            rd(9'h00C, st);
        chk("status", {27'h0, ex}, st);
        rd(9'h008, q);
        chk("fsr", ex == 5'h10 ? {nzcv, pre[27:1], inv} : pre, q);
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (k = 0; k < 4; k++) begin
            rd({5'h0, k[1:0], 2'h0}, got);
            chk("reset", 32'h0, got);
        end
        for (k = 0; k < 64; k++)
            setr(k[5:0], rnd());
        for (k = 0; k < 12; k++)
            setr(k[5:0], iv[k]);
        wr(9'h010, rnd());
        rd(9'h010, got);
        chk("unmapped", 32'h0, got);
        run(base_ctrl, mk(4'hE, 0, 0, 2'h2, 1, 1));
        run(base_ctrl, mk(4'hE, 1, 0, 2'h2, 1, 0));
        run(base_ctrl, mk(4'hE, 0, 0, 2'h2, 1, 0));
        run(base_ctrl, mk(4'hE, 0, 0, 2'h2, 1, 2));
        run(base_ctrl, mk(4'hE, 2, 0, 2'h2, 0, 0));
        run(base_ctrl, mk(4'hE, 4, 0, 2'h2, 0, 0));
        run(base_ctrl, mk(4'hE, 3, 1, 2'h2, 1, 0));
        run(base_ctrl, mk(4'hE, 1, 1, 2'h2, 0, 31));
        run(base_ctrl, mk(4'hE, 5, 0, 2'h1, 1, 6));
        run(base_ctrl, mk(4'hE, 7, 1, 2'h1, 1, 0));
        run(base_ctrl, mk(4'hE, 4, 0, 2'h3, 1, 5));
        run(base_ctrl, mk(4'hE, 5, 1, 2'h3, 0, 0));
        run(base_ctrl, mk(4'hE, 20, 0, 2'h3, 1, 21));
        run(base_ctrl, mk(4'hE, 0, 0, 2'h0, 1, 1));
        run(32'h1, mk(4'hE, 5, 0, 2'h1, 1, 6));
        run(base_ctrl, mk(4'hF, 0, 0, 2'h2, 1, 1));
        run(base_ctrl, rnd());
        run(base_ctrl, mk(4'h0, 0, 0, 2'h2, 1, 1));
        run(base_ctrl | 32'h4000_0000, mk(4'h0, 0, 0, 2'h2, 1, 1));
        run(base_ctrl | 32'h4000_0000, mk(4'h1, 0, 0, 2'h2, 1, 1));
        run(32'h2, mk(4'hE, 0, 0, 2'h2, 1, 1));
        run(base_ctrl | 32'h8, mk(4'hE, 0, 0, 2'h2, 1, 1));
        run(base_ctrl | 32'h18, mk(4'hE, 0, 0, 2'h2, 1, 1));
        for (k = 0; k < 4; k++) begin
            run(base_ctrl | 32'h4 | {25'h0, k[1:0], 5'h0}, mk(4'h0, 5, 0, 2'h1, 1, 6));
            run(base_ctrl | 32'hE18 | {25'h0, k[1:0], 5'h0}, mk(4'hE, 5, 0, 2'h1, 1, 6));
        end
        for (k = 0; k < 14; k++) begin
            r = rnd() & 32'hF000_0000;
            run(base_ctrl | r, mk(k[3:0], 1, 0, 2'h2, 1, 0));
            run(base_ctrl | r | 32'h18 | {20'h0, k[3:0], 8'h0}, mk(4'hE, 1, 0, 2'h2, 1, 0));
        end
        for (k = 0; k < 40; k++) begin
            r = rnd();
            setr(r[21:16], rnd() | (r[22] ? 32'h7F80_0000 : 32'h0));
            run(base_ctrl | {29'h0, r[2], 2'h0}, mk(4'hE, r[8:4], r[9], {1'b1, r[10]}, r[11], r[16:12]));
        end
        stop_test();
    end
endmodule
